// ===== src/pse_core_state.sv
// Purpose: Status registers, banked register mapping and exception entry sequencing.
// Assumes: Core requests are synchronous to clk_sys and sampled every cycle.
// Notes: Exception entry completes in a single cycle and outranks every other update.
`timescale 1ns/10ps
module pse_core_state
   import pse_pkg::*;
#(
   parameter int XLEN = 32
) (
   // Clock and reset
   input  wire logic            clk_sys,
   input  wire logic            rstn,
   // AHB-Lite slave
   input  wire logic            hsel,
   input  wire logic [31:0]     haddr,
   input  wire logic [1:0]      htrans,
   input  wire logic            hwrite,
   input  wire logic [2:0]      hsize,
   input  wire logic [31:0]     hwdata,
   input  wire logic            hready,
   output logic                 hreadyout,
   output logic                 hresp,
   output logic      [31:0]     hrdata,
   // Core register access
   input  wire logic [3:0]      coreRdIdx,
   output logic      [XLEN-1:0] coreRdData,
   input  wire logic            coreWrEn,
   input  wire logic [3:0]      coreWrIdx,
   input  wire logic [XLEN-1:0] coreWrData,
   input  wire logic            hiRegOp,
   // Condition flags and state switch
   input  wire logic            flagWrEn,
   input  wire logic [3:0]      flagIn,
   input  wire logic            stateWrEn,
   input  wire logic            stateIn,
   input  wire logic [3:0]      condCode,
   input  wire logic            isBranch,
   output logic                 condPass,
   // Exception requests
   input  wire logic [XLEN-1:0] pcCurrent,
   input  wire logic            dataAbortReq,
   input  wire logic            fastIrqReq,
   input  wire logic            normIrqReq,
   input  wire logic            prefetchAbortReq,
   input  wire logic            undefReq,
   input  wire logic            software_trap,
   // Exception results and status
   output logic                 excTaken,
   output pse_exc_t             excKind,
   output logic      [XLEN-1:0] fetchAddr,
   output logic      [4:0]      curMode,
   output logic                 state_indicator_out
);
   logic [31:0] current_status_reg;
   logic [31:0] current_status_next;
   logic [31:0] saved_status_reg  [SAVED_SLOTS];
   logic [31:0] saved_status_next [SAVED_SLOTS];
   logic        excTaken_reg;
   logic        excTaken_next;
   pse_exc_t    excKind_reg;
   pse_exc_t    excKind_next;
   logic [31:0] fetchAddr_reg;
   logic [31:0] fetchAddr_next;
   logic        dpWrite_reg;
   logic        dpWrite_next;
   logic        dpRead_reg;
   logic        dpRead_next;
   logic [7:0]  dpAddr_reg;
   logic [7:0]  dpAddr_next;

   pse_exc_t    excSel;
   logic [4:0]  excMode;
   logic [2:0]  excSlot;
   logic [31:0] excVector;
   logic [31:0] linkOfs;
   logic [4:0]  linkPhys;
   logic [4:0]  rdPhys;
   logic [4:0]  wrPhys;
   logic        accessOk;
   logic        wrAccessOk;
   logic        privileged;
   logic        busWrCur;
   logic        busWrSaved;
   logic [2:0]  busSlot;
   logic [XLEN-1:0] storeRd;

   // Logical register to physical register under the given mode.
   function automatic logic [4:0] phys_index(input logic [4:0] mode, input logic [3:0] idx);
      logic [4:0] base;
      base = PHY_R13_USR;
      if (idx < 4'h8) begin
         return {1'b0, idx};
      end
      if (idx == 4'hF) begin
         return PHY_PC;
      end
      if (mode == MODE_FIQ) begin
         return PHY_FIQ_R8 + 5'({1'b0, idx} - 5'h08);
      end
      if (idx < 4'hD) begin
         return {1'b0, idx};
      end
      case (mode)
         MODE_IRQ: base = PHY_R13_IRQ;
         MODE_SVC: base = PHY_R13_SVC;
         MODE_ABT: base = PHY_R13_ABT;
         MODE_UND: base = PHY_R13_UND;
         default:  base = PHY_R13_USR;
      endcase
      return base + {4'h0, idx[0] ^ 1'b1};
   endfunction

   // Condition code evaluation on the current flags.
   function automatic logic cond_eval(input logic [3:0] cc, input logic [31:0] st);
      logic n, z, c, v, r;
      n = st[BIT_NEG];
      z = st[BIT_ZERO];
      c = st[BIT_CARY];
      v = st[BIT_OVFL];
      case (cc[3:1])
         3'h0:    r = z;
         3'h1:    r = c;
         3'h2:    r = n;
         3'h3:    r = v;
         3'h4:    r = c & ~z;
         3'h5:    r = (n == v);
         3'h6:    r = ~z & (n == v);
         default: r = 1'b1;
      endcase
      if (cc == 4'hF) begin
         r = 1'b0;
      end else if (cc != 4'hE) begin
         r = r ^ cc[0];
      end
      return r;
   endfunction

   assign curMode             = current_status_reg[4:0];
   assign state_indicator_out = current_status_reg[BIT_STAT];
   assign privileged          = (curMode != MODE_USR);
   // Only branches carry a condition in the compact state.
   assign condPass = (current_status_reg[BIT_STAT] && !isBranch) ? 1'b1
                     : cond_eval(condCode, current_status_reg);
   // Registers 8 to 12 stay hidden in the compact state unless a high-register op asks.
   assign rdPhys     = phys_index(curMode, coreRdIdx);
   assign wrPhys     = phys_index(curMode, coreWrIdx);
   assign accessOk   = !current_status_reg[BIT_STAT] || (coreRdIdx < 4'h8)
                       || (coreRdIdx > 4'hC) || hiRegOp;
   assign wrAccessOk = !current_status_reg[BIT_STAT] || (coreWrIdx < 4'h8)
                       || (coreWrIdx > 4'hC) || hiRegOp;
   assign coreRdData = accessOk ? storeRd : '0;
   // Fixed priority selection; masked interrupts are not even seen.
   always_comb begin
      excSel = EXC_NONE;
      if (dataAbortReq) begin
         excSel = EXC_DABT;
      end else if (fastIrqReq && !current_status_reg[BIT_FIQD]) begin
         excSel = EXC_FIQ;
      end else if (normIrqReq && !current_status_reg[BIT_IRQD]) begin
         excSel = EXC_IRQ;
      end else if (prefetchAbortReq) begin
         excSel = EXC_PABT;
      end else if (undefReq) begin
         excSel = EXC_UND;
      end else if (software_trap) begin
         excSel = EXC_TRAP;
      end
   end

   // Target mode, slot, vector and link offset of the selected exception.
   always_comb begin
      excMode   = MODE_SVC;
      excSlot   = SLOT_SVC;
      excVector = VEC_RESET;
      linkOfs   = OFS_FOUR;
      case (excSel)
         EXC_DABT: begin
            excMode   = MODE_ABT;
            excSlot   = SLOT_ABT;
            excVector = VEC_DABT;
            linkOfs   = OFS_EIGHT;
         end
         EXC_FIQ: begin
            excMode   = MODE_FIQ;
            excSlot   = SLOT_FIQ;
            excVector = VEC_FIQ;
         end
         EXC_IRQ: begin
            excMode   = MODE_IRQ;
            excSlot   = SLOT_IRQ;
            excVector = VEC_IRQ;
         end
         EXC_PABT: begin
            excMode   = MODE_ABT;
            excSlot   = SLOT_ABT;
            excVector = VEC_PABT;
         end
         EXC_UND: begin
            excMode   = MODE_UND;
            excSlot   = SLOT_UND;
            excVector = VEC_UND;
            linkOfs   = current_status_reg[BIT_STAT] ? OFS_TWO : OFS_FOUR;
         end
         EXC_TRAP: begin
            excMode   = MODE_SVC;
            excSlot   = SLOT_SVC;
            excVector = VEC_TRAP;
            linkOfs   = current_status_reg[BIT_STAT] ? OFS_TWO : OFS_FOUR;
         end
         default: excMode = MODE_SVC;
      endcase
   end
   assign linkPhys = phys_index(excMode, 4'hE);
   // The exception's link is written through port A and its program counter through port B, which wins.
   pse_reg_store #(
      .DEPTH (PHYS_REGS),
      .WIDTH (XLEN),
      .AW    (5)
   ) u_store (
      .clk_sys (clk_sys),
      .rstn    (rstn),
      .weA     ((excSel != EXC_NONE) || (coreWrEn && wrAccessOk)),
      .waA     ((excSel != EXC_NONE) ? linkPhys : wrPhys),
      .wdA     ((excSel != EXC_NONE) ? XLEN'(pcCurrent + linkOfs) : coreWrData),
      .weB     (excSel != EXC_NONE),
      .waB     (PHY_PC),
      .wdB     (XLEN'(excVector)),
      .ra      (rdPhys),
      .rd      (storeRd)
   );

   // Bus address phase is captured and acted on in the data phase.
   always_comb begin
      dpWrite_next = 1'b0;
      dpRead_next  = 1'b0;
      dpAddr_next  = dpAddr_reg;
      if (hsel && htrans[1] && hready) begin
         dpWrite_next = hwrite;
         dpRead_next  = !hwrite;
         dpAddr_next  = haddr[7:0];
      end
   end
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         dpWrite_reg <= 1'b0;
         dpRead_reg  <= 1'b0;
         dpAddr_reg  <= 8'h00;
      end else begin
         dpWrite_reg <= dpWrite_next;
         dpRead_reg  <= dpRead_next;
         dpAddr_reg  <= dpAddr_next;
      end
   end
   assign busWrCur   = dpWrite_reg && (dpAddr_reg == ADDR_CUR);
   assign busWrSaved = dpWrite_reg && (dpAddr_reg >= ADDR_SAVED_LO)
                       && (dpAddr_reg <= ADDR_SAVED_HI) && (dpAddr_reg[1:0] == 2'b00);
   assign busSlot    = 3'(8'(dpAddr_reg - ADDR_SAVED_LO) >> 2);
   assign hreadyout  = 1'b1;
   assign hresp      = 1'b0;
   // Data phase read straight off the status flops, so a write just before is seen.
   always_comb begin
      hrdata = 32'h0000_0000;
      if (dpRead_reg && (dpAddr_reg == ADDR_CUR)) begin
         hrdata = current_status_reg;
      end else if (dpRead_reg && (dpAddr_reg >= ADDR_SAVED_LO)
                   && (dpAddr_reg <= ADDR_SAVED_HI) && (dpAddr_reg[1:0] == 2'b00)) begin
         hrdata = saved_status_reg[busSlot];
      end
   end
   // Status update: exception entry first, then software, then flags and state switch.
   always_comb begin
      current_status_next = current_status_reg;
      for (int i = 0; i < SAVED_SLOTS; i++) begin
         saved_status_next[i] = saved_status_reg[i];
      end
      if (busWrSaved) begin
         saved_status_next[busSlot] = hwdata;
      end
      if (excSel != EXC_NONE) begin
         saved_status_next[excSlot]    = current_status_reg;
         current_status_next[4:0]      = excMode;
         current_status_next[BIT_STAT] = 1'b0;
         current_status_next[BIT_IRQD] = 1'b1;
         if (excSel == EXC_FIQ) begin
            current_status_next[BIT_FIQD] = 1'b1;
         end
      end else if (busWrCur) begin
         if (privileged) begin
            current_status_next = hwdata;
         end else begin
            current_status_next[31:8] = hwdata[31:8];
         end
      end else begin
         if (flagWrEn) begin
            current_status_next[BIT_NEG:BIT_OVFL] = flagIn;
         end
         if (stateWrEn) begin
            current_status_next[BIT_STAT] = stateIn;
         end
      end
   end

   // One copy of each status register serves both instruction states.
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         current_status_reg <= STATUS_RESET;
         for (int i = 0; i < SAVED_SLOTS; i++) begin
            saved_status_reg[i] <= WORD_RESET;
         end
      end else begin
         current_status_reg <= current_status_next;
         for (int i = 0; i < SAVED_SLOTS; i++) begin
            saved_status_reg[i] <= saved_status_next[i];
         end
      end
   end

   // Redirect report; reset leaves fetch pointing at the reset vector.
   always_comb begin
      excTaken_next  = (excSel != EXC_NONE);
      excKind_next   = excSel;
      fetchAddr_next = (excSel != EXC_NONE) ? excVector : fetchAddr_reg;
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         excTaken_reg  <= 1'b0;
         excKind_reg   <= EXC_NONE;
         fetchAddr_reg <= VEC_RESET;
      end else begin
         excTaken_reg  <= excTaken_next;
         excKind_reg   <= excKind_next;
         fetchAddr_reg <= fetchAddr_next;
      end
   end

   assign excTaken  = excTaken_reg;
   assign excKind   = excKind_reg;
   assign fetchAddr = XLEN'(fetchAddr_reg);
endmodule // pse_core_state

// ===== src/pse_pkg.sv
// Purpose: Shared constants and types for the processor status and exception entry block.
// Assumes: 32-bit data path, five-bit mode field, one core clock.
// Notes: Bus offsets are byte addresses on the register bus.
package pse_pkg;

   // Status register field positions.
   localparam int BIT_NEG  = 31;
   localparam int BIT_ZERO = 30;
   localparam int BIT_CARY = 29;
   localparam int BIT_OVFL = 28;
   localparam int BIT_IRQD = 7;
   localparam int BIT_FIQD = 6;
   localparam int BIT_STAT = 5;

   // Mode field encodings.
   localparam logic [4:0] MODE_USR = 5'h10;
   localparam logic [4:0] MODE_FIQ = 5'h11;
   localparam logic [4:0] MODE_IRQ = 5'h12;
   localparam logic [4:0] MODE_SVC = 5'h13;
   localparam logic [4:0] MODE_ABT = 5'h17;
   localparam logic [4:0] MODE_UND = 5'h1B;
   localparam logic [4:0] MODE_SYS = 5'h1F;

   // Value after reset: supervisor, both interrupts disabled, wide state.
   localparam logic [31:0] STATUS_RESET = 32'h0000_00D3;
   localparam logic [31:0] WORD_RESET   = 32'h0000_0000;

   // Exception vectors.
   localparam logic [31:0] VEC_RESET = 32'h0000_0000;
   localparam logic [31:0] VEC_UND   = 32'h0000_0004;
   localparam logic [31:0] VEC_TRAP  = 32'h0000_0008;
   localparam logic [31:0] VEC_PABT  = 32'h0000_000C;
   localparam logic [31:0] VEC_DABT  = 32'h0000_0010;
   localparam logic [31:0] VEC_IRQ   = 32'h0000_0018;
   localparam logic [31:0] VEC_FIQ   = 32'h0000_001C;

   // Link offsets added to the address of the current instruction.
   localparam logic [31:0] OFS_TWO   = 32'h0000_0002;
   localparam logic [31:0] OFS_FOUR  = 32'h0000_0004;
   localparam logic [31:0] OFS_EIGHT = 32'h0000_0008;

   // Physical register file layout.
   localparam int          PHYS_REGS   = 31;
   localparam logic [4:0]  PHY_R13_USR = 5'h0D;
   localparam logic [4:0]  PHY_FIQ_R8  = 5'h0F;
   localparam logic [4:0]  PHY_R13_IRQ = 5'h16;
   localparam logic [4:0]  PHY_R13_SVC = 5'h18;
   localparam logic [4:0]  PHY_R13_ABT = 5'h1A;
   localparam logic [4:0]  PHY_R13_UND = 5'h1C;
   localparam logic [4:0]  PHY_PC      = 5'h1E;

   // Saved status slots.
   localparam logic [2:0] SLOT_FIQ = 3'h0;
   localparam logic [2:0] SLOT_IRQ = 3'h1;
   localparam logic [2:0] SLOT_SVC = 3'h2;
   localparam logic [2:0] SLOT_ABT = 3'h3;
   localparam logic [2:0] SLOT_UND = 3'h4;
   localparam int         SAVED_SLOTS = 5;

   // Register bus byte offsets.
   localparam logic [7:0] ADDR_CUR      = 8'h00;
   localparam logic [7:0] ADDR_SAVED_LO = 8'h04;
   localparam logic [7:0] ADDR_SAVED_HI = 8'h14;

   typedef enum logic [2:0] {
      EXC_NONE = 3'b000,
      EXC_DABT = 3'b001,
      EXC_FIQ  = 3'b010,
      EXC_IRQ  = 3'b011,
      EXC_PABT = 3'b100,
      EXC_UND  = 3'b101,
      EXC_TRAP = 3'b110
   } pse_exc_t;

endpackage

// ===== src/pse_reg_store.sv
// Purpose: Flip-flop register storage with two write ports and one read port.
// Assumes: Port B has priority when both ports write the same entry.
// Notes: Synchronous active-low reset clears every entry.
`timescale 1ns/10ps
module pse_reg_store #(
   parameter int DEPTH = 31,
   parameter int WIDTH = 32,
   parameter int AW    = 5
) (
   // Clock and reset
   input  wire logic             clk_sys,
   input  wire logic             rstn,
   // Write port A
   input  wire logic             weA,
   input  wire logic [AW-1:0]    waA,
   input  wire logic [WIDTH-1:0] wdA,
   // Write port B
   input  wire logic             weB,
   input  wire logic [AW-1:0]    waB,
   input  wire logic [WIDTH-1:0] wdB,
   // Read port
   input  wire logic [AW-1:0]    ra,
   output logic      [WIDTH-1:0] rd
);
   logic [WIDTH-1:0] mem_reg  [DEPTH];
   logic [WIDTH-1:0] mem_next [DEPTH];

   always_comb begin
      for (int i = 0; i < DEPTH; i++) begin
         mem_next[i] = mem_reg[i];
         if (weA && (waA == AW'(i))) begin
            mem_next[i] = wdA;
         end
         if (weB && (waB == AW'(i))) begin
            mem_next[i] = wdB;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      for (int i = 0; i < DEPTH; i++) begin
         if (!rstn) begin
            mem_reg[i] <= '0;
         end else begin
            mem_reg[i] <= mem_next[i];
         end
      end
   end

   // Reads outside the array return zero instead of an unknown.
   assign rd = (ra < AW'(DEPTH)) ? mem_reg[ra] : '0;
endmodule // pse_reg_store

// ===== test/pse_core_state_sva.sv
// Purpose: Port-level checks of exception entry and status read-back.
// Assumes: One clock domain with synchronous active-low reset.
// Notes: The interrupt masks are not visible here, so masking is judged by the bench.
`timescale 1ns/10ps
module pse_core_state_chk
   import pse_pkg::*;
#(
   parameter int XLEN = 32
) (
   // Clock and reset
   input wire logic            clk_sys,
   input wire logic            rstn,
   // Bus
   input wire logic            hsel,
   input wire logic [31:0]     haddr,
   input wire logic [1:0]      htrans,
   input wire logic            hwrite,
   input wire logic            hready,
   input wire logic [31:0]     hrdata,
   // Requests
   input wire logic            dataAbortReq,
   input wire logic            fastIrqReq,
   input wire logic            normIrqReq,
   input wire logic            prefetchAbortReq,
   input wire logic            undefReq,
   input wire logic            software_trap,
   // Results
   input wire logic            excTaken,
   input pse_exc_t             excKind,
   input wire logic [XLEN-1:0] fetchAddr,
   input wire logic [4:0]      curMode,
   input wire logic            state_indicator_out
);
   logic hiReq;
   logic anyReq;
   assign hiReq  = dataAbortReq | fastIrqReq | normIrqReq;
   assign anyReq = hiReq | prefetchAbortReq | undefReq | software_trap;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   a_dabt_first: assert property (dataAbortReq |=> excTaken && excKind == EXC_DABT
      && fetchAddr == VEC_DABT && curMode == MODE_ABT) else $error("data abort entry wrong");
   a_und_entry: assert property (undefReq && !hiReq && !prefetchAbortReq
      |=> curMode == MODE_UND && fetchAddr == VEC_UND) else $error("undefined entry wrong");
   a_trap_entry: assert property (software_trap && !hiReq && !prefetchAbortReq && !undefReq
      |=> curMode == MODE_SVC && fetchAddr == VEC_TRAP) else $error("trap entry wrong");
   a_wide_after: assert property ($rose(excTaken) |-> !state_indicator_out)
      else $error("state bit kept on entry");
   a_fiq_vector: assert property (excTaken && excKind == EXC_FIQ |->
      fetchAddr == VEC_FIQ ##0 curMode == MODE_FIQ) else $error("fast entry wrong");
   a_irq_vector: assert property (excTaken && excKind == EXC_IRQ |->
      fetchAddr == VEC_IRQ && curMode == MODE_IRQ) else $error("normal entry wrong");
   a_pabt_vector: assert property (excTaken && excKind == EXC_PABT |->
      fetchAddr == VEC_PABT && curMode == MODE_ABT) else $error("prefetch entry wrong");
   a_no_spurious: assert property (!anyReq |=> !excTaken)
      else $error("entry without request");
   a_status_read: assert property (hsel && htrans[1] && hready && !hwrite && haddr[7:0] == ADDR_CUR
      |=> hrdata[5:0] == {state_indicator_out, curMode}) else $error("status read wrong");
endmodule // pse_core_state_chk

// ===== test/test_pse_core_state.sv
// Purpose: Directed bench for status registers, banking and exception entry.
// Assumes: The slave answers with zero wait states, but the master still waits.
// Notes: Each scenario checks its own results before returning.
`timescale 1ns/10ps
module test_pse_core_state;
   import pse_pkg::*;
   logic        clk_sys = 1'h0;
   logic        rstn = 1'h0;
   logic        hsel = 1'h0;
   logic        hwrite = 1'h0;
   logic [1:0]  htrans = 2'h0;
   logic [31:0] haddr = 32'h0000_0000;
   logic [31:0] hwdata = 32'h0000_0000;
   logic [31:0] coreWrData = 32'h0000_0000;
   logic [31:0] pcCurrent = 32'h0000_0000;
   logic [3:0]  coreRdIdx = 4'h0;
   logic [3:0]  coreWrIdx = 4'h0;
   logic [3:0]  flagIn = 4'h0;
   logic [3:0]  condCode = 4'h0;
   logic        coreWrEn = 1'h0;
   logic        hiRegOp = 1'h0;
   logic        flagWrEn = 1'h0;
   logic        stateWrEn = 1'h0;
   logic        stateIn = 1'h0;
   logic        isBranch = 1'h0;
   logic [5:0]  reqs = 6'h00;
   logic        hreadyout, hresp, condPass, excTaken, state_indicator_out;
   logic [31:0] hrdata, coreRdData, fetchAddr;
   logic [4:0]  curMode;
   pse_exc_t    excKind;
   int          error_cnt = 0;
   int          total_checks = 0;

   pse_core_state u_pse_core_state (.clk_sys, .rstn, .hsel, .haddr, .htrans, .hwrite,
      .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .coreRdIdx,
      .coreRdData, .coreWrEn, .coreWrIdx, .coreWrData, .hiRegOp, .flagWrEn, .flagIn,
      .stateWrEn, .stateIn, .condCode, .isBranch, .condPass, .pcCurrent,
      .dataAbortReq(reqs[5]), .fastIrqReq(reqs[4]), .normIrqReq(reqs[3]),
      .prefetchAbortReq(reqs[2]), .undefReq(reqs[1]), .software_trap(reqs[0]),
      .excTaken, .excKind, .fetchAddr, .curMode, .state_indicator_out);

   always #10 clk_sys = ~clk_sys;

   task automatic tally_and_finish;
      if (error_cnt == 0 && total_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // The address phase is held until hready is seen high, as the bus demands.
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      @(posedge clk_sys);
      hsel <= 1'h1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr <= {24'h00_0000, a};
      do @(posedge clk_sys); while (hreadyout !== 1'h1);
      hsel <= 1'h0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk_sys); while (hreadyout !== 1'h1);
      q = hrdata;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'h1, a, d, q);
   endtask

   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] q;
      bus(1'h0, a, 32'h0000_0000, q);
      chk(q, exp);
      chk(32'({hreadyout, hresp}), 32'h0000_0002);
   endtask

   task automatic creg(input logic [3:0] idx, input logic hi, input logic [31:0] exp);
      @(posedge clk_sys);
      coreRdIdx <= idx;
      hiRegOp <= hi;
      @(negedge clk_sys);
      chk(coreRdData, exp);
   endtask

   task automatic cwr(input logic [3:0] idx, input logic [31:0] d);
      @(posedge clk_sys);
      coreWrEn <= 1'h1;
      coreWrIdx <= idx;
      coreWrData <= d;
      @(posedge clk_sys);
      coreWrEn <= 1'h0;
   endtask

   // A request is held one cycle only, since a held one is taken again.
   task automatic exc(input logic [5:0] r, input logic [31:0] pc);
      @(posedge clk_sys);
      reqs <= r;
      pcCurrent <= pc;
      @(posedge clk_sys);
      reqs <= 6'h00;
      @(negedge clk_sys);
      chk(32'(excTaken), 32'h0000_0001);
   endtask

   task automatic t_reset;
      rdc(ADDR_CUR, STATUS_RESET);
      chk(fetchAddr, VEC_RESET);
      for (int i = 1; i <= SAVED_SLOTS; i++) begin
         rdc(8'(4 * i), 32'h0000_0000);
      end
      rdc(8'h18, 32'h0000_0000);
   endtask

   task automatic t_compact;
      cwr(4'h0, 32'h1234_5678);
      cwr(4'h8, 32'h0000_8888);
      cwr(4'hD, 32'h0000_5AD0);
      @(posedge clk_sys);
      stateWrEn <= 1'h1;
      stateIn <= 1'h1;
      @(posedge clk_sys);
      stateWrEn <= 1'h0;
      @(negedge clk_sys);
      chk(32'(state_indicator_out), 32'h0000_0001);
      rdc(ADDR_CUR, 32'h0000_00F3);
      creg(4'h0, 1'h0, 32'h1234_5678);
      creg(4'h8, 1'h0, 32'h0000_0000);
      creg(4'h8, 1'h1, 32'h0000_8888);
      creg(4'hD, 1'h0, 32'h0000_5AD0);
      exc(6'h02, 32'h0000_0200);
      chk(32'(state_indicator_out), 32'h0000_0000);
      creg(4'hE, 1'h0, 32'h0000_0202);
      rdc(8'h14, 32'h0000_00F3);
   endtask

   task automatic t_banks;
      wr(ADDR_CUR, 32'h0000_00DF);
      creg(4'hD, 1'h0, 32'h0000_0000);
      wr(ADDR_CUR, 32'h0000_00D1);
      creg(4'h8, 1'h0, 32'h0000_0000);
      wr(ADDR_CUR, 32'h0000_00D3);
      creg(4'hD, 1'h0, 32'h0000_5AD0);
      creg(4'h8, 1'h0, 32'h0000_8888);
   endtask

   task automatic ecase(input logic [31:0] pre, input logic [5:0] r, input pse_exc_t k,
                        input logic [4:0] m, input logic [31:0] v, input logic [31:0] ofs,
                        input logic [7:0] slot);
      wr(ADDR_CUR, pre);
      exc(r, 32'h0000_0100);
      chk(32'(excKind), 32'(k));
      chk(fetchAddr, v);
      chk(32'(curMode), 32'(m));
      creg(4'hE, 1'h0, 32'h0000_0100 + ofs);
      rdc(slot, pre);
      rdc(ADDR_CUR, {pre[31:8], 1'h1, pre[6] | (m == MODE_FIQ), 1'h0, m});
   endtask

   task automatic t_user;
      wr(ADDR_CUR, 32'h0000_0010);
      wr(ADDR_CUR, 32'hA000_00D3);
      rdc(ADDR_CUR, 32'hA000_0010);
      @(posedge clk_sys);
      flagWrEn <= 1'h1;
      flagIn <= 4'h4;
      @(posedge clk_sys);
      flagWrEn <= 1'h0;
      rdc(ADDR_CUR, 32'h4000_0010);
      // The last step runs a failing condition outside a branch in the compact state.
      for (int i = 0; i < 5; i++) begin
         @(posedge clk_sys);
         stateWrEn <= (i == 2);
         stateIn <= 1'h1;
         condCode <= (i == 4) ? 4'h1 : 4'(i % 2);
         isBranch <= (i == 3);
         @(negedge clk_sys);
         chk(32'(condPass), (i % 2 == 0) ? 32'h0000_0001 : 32'h0000_0000);
      end
   endtask

   initial begin
      repeat (6) @(posedge clk_sys);
      rstn <= 1'h1;
      t_reset();
      t_compact();
      t_banks();
      ecase(32'h6000_0013, 6'h3F, EXC_DABT, MODE_ABT, VEC_DABT, OFS_EIGHT, 8'h10);
      ecase(32'h0000_0093, 6'h1F, EXC_FIQ, MODE_FIQ, VEC_FIQ, OFS_FOUR, 8'h04);
      ecase(32'h0000_00D3, 6'h1C, EXC_PABT, MODE_ABT, VEC_PABT, OFS_FOUR, 8'h10);
      ecase(32'h0000_0013, 6'h0E, EXC_IRQ, MODE_IRQ, VEC_IRQ, OFS_FOUR, 8'h08);
      ecase(32'h0000_0013, 6'h02, EXC_UND, MODE_UND, VEC_UND, OFS_FOUR, 8'h14);
      ecase(32'h0000_0013, 6'h01, EXC_TRAP, MODE_SVC, VEC_TRAP, OFS_FOUR, 8'h0C);
      t_user();
      tally_and_finish();
   end

   // The whole run needs well under a thousand cycles.
   initial begin
      repeat (5000) @(posedge clk_sys);
      error_cnt++;
      tally_and_finish();
   end
endmodule // test_pse_core_state

bind pse_core_state pse_core_state_chk #(.XLEN(XLEN)) u_pse_core_state_chk (.clk_sys,
   .rstn, .hsel, .haddr, .htrans, .hwrite, .hready, .hrdata, .dataAbortReq, .fastIrqReq,
   .normIrqReq, .prefetchAbortReq, .undefReq, .software_trap, .excTaken, .excKind,
   .fetchAddr, .curMode, .state_indicator_out);
